// [hw/stps_pkg.sv]
/*
  Constants for the sequencer time-out supervision and primary status block.
  Assumes a byte-addressed register port with 32-bit words.
*/
package stps_pkg;
  localparam int ADDR_W = 12;
  localparam int NUM_TASKS = 2;

  // Register byte offsets.
  localparam logic [ADDR_W-1:0] OFF_TASK0_TIMEOUT_CONFIG = 12'h0d4;
  localparam logic [ADDR_W-1:0] OFF_TASK1_TIMEOUT_CONFIG = 12'h0d8;
  localparam logic [ADDR_W-1:0] OFF_PRIMARY_STATUS = 12'h110;
  localparam logic [ADDR_W-1:0] OFF_INTERRUPT_MASK = 12'h118;
  localparam logic [ADDR_W-1:0] OFF_INTERRUPT_PENDING = 12'h11c;

  // Time-out configuration fields.
  localparam int CFG_SYNC_EN_BIT = 31;
  localparam int CFG_CLOCK_EN_BIT = 30;
  localparam int CFG_PORT_SEL_BIT = 29;
  localparam int CFG_SYNC_LIMIT_HI = 27;
  localparam int CFG_SYNC_LIMIT_LO = 24;
  localparam int CFG_CLOCK_LIMIT_HI = 23;
  localparam int CFG_CLOCK_LIMIT_LO = 0;
  localparam int CLOCK_CNT_W = 24;
  localparam int SYNC_CNT_W = 4;
  localparam logic [31:0] CFG_WRITE_MASK = 32'hefff_ffff;
  localparam logic [31:0] CFG_RESET = 32'h0000_0000;

  // Implemented primary status bits are 31 down to 21.
  localparam int PS_LO = 21;
  localparam int PS_W = 11;
  localparam int PS_BUS_PARITY = 10;
  localparam int PS_BUS_ABORT = 9;
  localparam int PS_RT_PARITY = 8;
  localparam int PS_CMD_IRQ0 = 6;
  localparam int PS_LATE0 = 4;
  localparam int PS_ERR0 = 2;
  localparam int PS_TIMEOUT0 = 0;
  localparam logic [PS_W-1:0] PS_RESET = 11'h000;
  localparam logic [PS_W-1:0] MASK_RESET = 11'h000;
  localparam logic [31:0] RDATA_IDLE = 32'h0000_0000;
endpackage

// [hw/stps_top.sv]
/*
  Time-out supervision for the two command list sequencer tasks, the upper
  primary status bits, the interrupt mask and pending registers and the
  register port. Sequencer inputs come from logic on the same clock; the two
  vertical sync inputs are pins and are synchronised here.
*/
// The strobed register port was left to the implementer.
// What this block does
// - A zero count in the selected field never produces a time-out.
// - Mode bits 31 and 30 pick none, clock, sync or both checks.
// - Bit 29 picks the sync source: one is port A, zero port B.
// - Bits 27 to 24 give the sync time-out, 1 to 15 syncs.
// - Bits 23 to 0 give the clock time-out in bus clocks.
// - Each task has its own configuration governing its wait time-out checks.
// - Primary status summarises secondary status information.
// - Interrupts come only from primary status, gated by the mask register.
// - Enabled conditions set pending bits; writing one clears them.
// - Status is read-only; writing one raises its interrupt if enabled.
// - Bit 31 flags bus parity faults; pending set on its rising edge.
// - Bit 30 flags bus target or master aborts; pending on rising edge.
// - Bit 29 flags real-time parity faults since last sync or wait.
// - Bits 28 and 27 flag command interrupts of task 1 and 0.
// - Bits 26 and 25 flag lateness per task, cleared on task start.
// - Bits 24 and 23 follow task error summaries, cleared on task start.
// - Bit 22 flags task 1 wait time-out, cleared on task 1 start.
// - Bit 21 flags task 0 wait time-out, cleared on task 0 start.
`timescale 1ns/1ns
module stps_top #(
  parameter int ADDR_BITS = stps_pkg::ADDR_W
) (
  input wire logic i_ref_clk,
  input wire logic i_reset,
  input wire logic [ADDR_BITS-1:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic i_vsync_a,
  input wire logic i_vsync_b,
  input wire logic i_seq_running,
  input wire logic [stps_pkg::NUM_TASKS-1:0] i_task_start,
  input wire logic [stps_pkg::NUM_TASKS-1:0] i_task_wait,
  input wire logic [stps_pkg::NUM_TASKS-1:0] i_task_cmd_irq,
  input wire logic [stps_pkg::NUM_TASKS-1:0] i_task_late,
  input wire logic [stps_pkg::NUM_TASKS-1:0] i_task_error,
  input wire logic i_bus_parity_fault,
  input wire logic i_bus_abort_fault,
  input wire logic i_realtime_parity_fault,
  output logic [31:0] o_rdata,
  output logic [stps_pkg::NUM_TASKS-1:0] o_task_timeout_flag,
  output logic o_irq
);
  import stps_pkg::*;

  // The pending register at 0x11c needs at least nine address bits.
  if (ADDR_BITS < 9) begin : g_addr_check
    $error("stps_top: ADDR_BITS must reach offset 0x11c");
  end

  typedef struct packed {
    logic [NUM_TASKS-1:0][31:0] cfg;
    logic [NUM_TASKS-1:0][CLOCK_CNT_W-1:0] clk_cnt;
    logic [NUM_TASKS-1:0][SYNC_CNT_W-1:0] sync_cnt;
    logic [NUM_TASKS-1:0] wait_d;
    logic [NUM_TASKS-1:0] fired;
    logic [1:0][2:0] sync_sh;
    logic [1:0] sync_stable;
    logic [PS_W-1:0] status;
    logic [PS_W-1:0] status_d;
    logic [PS_W-1:0] mask;
    logic [PS_W-1:0] pend;
    logic [31:0] rdata;
    logic [NUM_TASKS-1:0] timeout_out;
    logic irq;
  } stps_state_t;

  stps_state_t state_reg;
  stps_state_t state_next;

  always_comb begin
    logic [1:0] sync_edge;
    logic [NUM_TASKS-1:0] wait_rise;
    logic [NUM_TASKS-1:0] timeout_hit;
    logic [PS_W-1:0] set_bits;
    logic [PS_W-1:0] clr_bits;
    logic [PS_W-1:0] soft_bits;
    logic [PS_W-1:0] pend_clr;
    logic [PS_W-1:0] rise;
    logic [CLOCK_CNT_W-1:0] clk_limit;
    logic [SYNC_CNT_W-1:0] sync_limit;
    logic sel_edge;
    logic rt_restart;
    sync_edge = '0;
    wait_rise = '0;
    timeout_hit = '0;
    set_bits = '0;
    clr_bits = '0;
    soft_bits = '0;
    pend_clr = '0;
    rise = '0;
    clk_limit = '0;
    sync_limit = '0;
    sel_edge = 1'b0;
    rt_restart = 1'b0;
    state_next = state_reg;

    // Pins pass three flops; a level counts once the last two agree.
    state_next.sync_sh[0] = {state_reg.sync_sh[0][1:0], i_vsync_a};
    state_next.sync_sh[1] = {state_reg.sync_sh[1][1:0], i_vsync_b};
    for (int p = 0; p < 2; p++) begin
      if (state_reg.sync_sh[p][1] == state_reg.sync_sh[p][2]) begin
        state_next.sync_stable[p] = state_reg.sync_sh[p][2];
        sync_edge[p] = state_reg.sync_sh[p][2] & ~state_reg.sync_stable[p];
      end
    end

    // Per-task wait supervision.
    for (int t = 0; t < NUM_TASKS; t++) begin
      wait_rise[t] = i_task_wait[t] & ~state_reg.wait_d[t];
      state_next.wait_d[t] = i_task_wait[t];
      clk_limit = state_reg.cfg[t][CFG_CLOCK_LIMIT_HI:CFG_CLOCK_LIMIT_LO];
      sync_limit = state_reg.cfg[t][CFG_SYNC_LIMIT_HI:CFG_SYNC_LIMIT_LO];
      sel_edge = state_reg.cfg[t][CFG_PORT_SEL_BIT] ? sync_edge[0] : sync_edge[1];
      if (wait_rise[t]) begin
        state_next.clk_cnt[t] = CLOCK_CNT_W'(1);
        state_next.sync_cnt[t] = '0;
        state_next.fired[t] = 1'b0;
      end else if (i_task_wait[t]) begin
        if (state_reg.clk_cnt[t] != '1) begin
          state_next.clk_cnt[t] = state_reg.clk_cnt[t] + CLOCK_CNT_W'(1);
        end
        if (sel_edge && state_reg.sync_cnt[t] != '1) begin
          state_next.sync_cnt[t] = state_reg.sync_cnt[t] + SYNC_CNT_W'(1);
        end
      end
      // Mode bits select checks; zero limit disables.
      if (state_reg.wait_d[t] && i_task_wait[t] && !state_reg.fired[t]) begin
        if (state_reg.cfg[t][CFG_CLOCK_EN_BIT] && clk_limit != '0 &&
            state_reg.clk_cnt[t] == clk_limit) begin
          timeout_hit[t] = 1'b1;
        end
        // Whichever limit is reached first wins.
        if (state_reg.cfg[t][CFG_SYNC_EN_BIT] && sync_limit != '0 &&
            state_reg.sync_cnt[t] == sync_limit) begin
          timeout_hit[t] = 1'b1;
        end
      end
      if (timeout_hit[t]) begin
        state_next.fired[t] = 1'b1;
      end

      set_bits[PS_CMD_IRQ0 + t] = i_task_cmd_irq[t];
      set_bits[PS_LATE0 + t] = i_task_late[t];
      set_bits[PS_ERR0 + t] = i_task_error[t];
      set_bits[PS_TIMEOUT0 + t] = timeout_hit[t];
      // Cleared when the task starts anew.
      if (i_task_start[t]) begin
        clr_bits[PS_LATE0 + t] = 1'b1;
        clr_bits[PS_ERR0 + t] = 1'b1;
        clr_bits[PS_TIMEOUT0 + t] = 1'b1;
      end
    end

    set_bits[PS_BUS_PARITY] = i_bus_parity_fault;
    set_bits[PS_BUS_ABORT] = i_bus_abort_fault;
    // Real-time window restarts at each wait while the sequencer runs, else at each sync.
    set_bits[PS_RT_PARITY] = i_realtime_parity_fault;
    rt_restart = i_seq_running ? (|wait_rise) : (|sync_edge);
    clr_bits[PS_RT_PARITY] = rt_restart;

    if (i_wr && i_addr == ADDR_BITS'(OFF_INTERRUPT_PENDING)) begin
      pend_clr = i_wdata[31:PS_LO];
    end
    // Event-only status bits fall together with their pending bits.
    clr_bits[PS_BUS_PARITY] = pend_clr[PS_BUS_PARITY];
    clr_bits[PS_BUS_ABORT] = pend_clr[PS_BUS_ABORT];
    for (int t = 0; t < NUM_TASKS; t++) begin
      clr_bits[PS_CMD_IRQ0 + t] = pend_clr[PS_CMD_IRQ0 + t];
    end

    // Set wins over clear so no event is lost.
    state_next.status = (state_reg.status & ~clr_bits) | set_bits;
    state_next.status_d = state_reg.status;

    // A written one raises the interrupt, storage stays untouched.
    if (i_wr && i_addr == ADDR_BITS'(OFF_PRIMARY_STATUS)) begin
      soft_bits = i_wdata[31:PS_LO];
    end

    // Pending follows the rising edge of each status bit.
    rise = state_reg.status & ~state_reg.status_d;
    // Only primary conditions, each gated by its mask bit.
    // Set wins over a clear in the same cycle.
    state_next.pend = (state_reg.pend & ~pend_clr) | ((rise | soft_bits) & state_reg.mask);
    state_next.irq = |(state_next.pend & state_reg.mask);
    state_next.timeout_out = state_next.status[PS_TIMEOUT0 +: NUM_TASKS];

    // Register writes.
    if (i_wr) begin
      unique case (i_addr)
        ADDR_BITS'(OFF_TASK0_TIMEOUT_CONFIG): begin
          state_next.cfg[0] = i_wdata & CFG_WRITE_MASK;
        end
        ADDR_BITS'(OFF_TASK1_TIMEOUT_CONFIG): begin
          state_next.cfg[1] = i_wdata & CFG_WRITE_MASK;
        end
        ADDR_BITS'(OFF_INTERRUPT_MASK): begin
          state_next.mask = i_wdata[31:PS_LO];
        end
        default: begin
        end
      endcase
    end

    // Read data stands for exactly one cycle after the strobe.
    state_next.rdata = RDATA_IDLE;
    if (i_rd) begin
      unique case (i_addr)
        ADDR_BITS'(OFF_TASK0_TIMEOUT_CONFIG): begin
          state_next.rdata = state_reg.cfg[0];
        end
        ADDR_BITS'(OFF_TASK1_TIMEOUT_CONFIG): begin
          state_next.rdata = state_reg.cfg[1];
        end
        ADDR_BITS'(OFF_PRIMARY_STATUS): begin
          state_next.rdata = {state_reg.status, 21'h00_0000};
        end
        ADDR_BITS'(OFF_INTERRUPT_MASK): begin
          state_next.rdata = {state_reg.mask, 21'h00_0000};
        end
        ADDR_BITS'(OFF_INTERRUPT_PENDING): begin
          state_next.rdata = {state_reg.pend, 21'h00_0000};
        end
        default: begin
          state_next.rdata = RDATA_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      state_reg.cfg <= {NUM_TASKS{CFG_RESET}};
      state_reg.clk_cnt <= '0;
      state_reg.sync_cnt <= '0;
      state_reg.wait_d <= '0;
      state_reg.fired <= '0;
      state_reg.sync_sh <= '0;
      state_reg.sync_stable <= '0;
      state_reg.status <= PS_RESET;
      state_reg.status_d <= PS_RESET;
      state_reg.mask <= MASK_RESET;
      state_reg.pend <= PS_RESET;
      state_reg.rdata <= RDATA_IDLE;
      state_reg.timeout_out <= '0;
      state_reg.irq <= 1'b0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign o_rdata = state_reg.rdata;
  assign o_task_timeout_flag = state_reg.timeout_out;
  assign o_irq = state_reg.irq;
endmodule // stps_top

// [tb/stps_props.sv]
/*
  Port-level checker for stps_top: read data, time-out timing, interrupts.
  Assumes it is bound to stps_top and sees only that module's ports.
*/
`timescale 1ns/1ns
module stps_props
  import stps_pkg::*;
#(
  parameter int ADDR_BITS = ADDR_W
) (
  input wire logic i_ref_clk,
  input wire logic i_reset,
  input wire logic [ADDR_BITS-1:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [1:0] i_task_start,
  input wire logic [1:0] i_task_wait,
  input wire logic i_bus_parity_fault,
  input wire logic [31:0] o_rdata,
  input wire logic [1:0] o_task_timeout_flag,
  input wire logic o_irq
);
  logic [31:0] cfg0_reg, mask_reg;
  wire logic no_check = cfg0_reg[31:30] == 2'h0;
  wire logic zero_lim = cfg0_reg[27:0] == 28'h000_0000;
  // Shadows are kept from writes, since the checker cannot see inside.
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      cfg0_reg <= 32'h0000_0000;
      mask_reg <= 32'h0000_0000;
    end else if (i_wr && i_addr == OFF_TASK0_TIMEOUT_CONFIG) begin
      cfg0_reg <= i_wdata;
    end else if (i_wr && i_addr == OFF_INTERRUPT_MASK) begin
      mask_reg <= i_wdata & 32'hffe0_0000;
    end
  end
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_reset);
  AST_READ_LOW: assert property ($past(i_rd) && $past(i_addr) == OFF_PRIMARY_STATUS |->
    o_rdata[20:0] == 21'h0_0000) else $error("status read shows low bits");
  AST_IRQ_GATE: assert property (i_wr && i_addr == OFF_INTERRUPT_MASK && i_wdata == 32'h0000_0000
    ##1 !(i_wr && i_addr == OFF_INTERRUPT_MASK) |=> !o_irq) else $error("irq with empty mask");
  AST_IRQ_CAUSE: assert property ($rose(o_irq) |-> $past(mask_reg) != 32'h0000_0000)
    else $error("irq rose while all masked");
  AST_TO_CLEAR0: assert property ($past(!i_task_wait[0]) && !i_task_wait[0] && i_task_start[0]
    |=> ##1 !o_task_timeout_flag[0]) else $error("task 0 flag survived start");
  AST_TO_CLOCK: assert property ($rose(i_task_wait[0]) && cfg0_reg == 32'h4000_0003
    && !o_task_timeout_flag[0] ##1 i_task_wait[0] [*3] |-> !o_task_timeout_flag[0] ##1 o_task_timeout_flag[0])
    else $error("clock time-out at wrong cycle");
  AST_ZERO_LIMIT: assert property (zero_lim && $past(zero_lim, 4) |-> !$rose(o_task_timeout_flag[0]))
    else $error("time-out with zero limit");
  AST_MODE_NONE: assert property (no_check && $past(no_check, 4) |-> !$rose(o_task_timeout_flag[0]))
    else $error("time-out with no check selected");
  AST_SW_IRQ: assert property (i_wr && i_addr == OFF_PRIMARY_STATUS && i_wdata[31] && mask_reg[31]
    |-> ##[1:3] o_irq) else $error("status write raised no irq");
  AST_PARITY_IRQ: assert property (i_bus_parity_fault && mask_reg[31] && !o_irq
    |=> !o_irq ##1 o_irq) else $error("parity irq latency wrong");
  cover property ($rose(o_task_timeout_flag[0]));
  cover property ($rose(o_task_timeout_flag[1]));
  cover property ($rose(o_irq));
endmodule // stps_props

bind stps_top stps_props #(.ADDR_BITS(ADDR_BITS)) u_props (.*);

// [tb/stps_partner.sv]
/*
  Far side model: the two sequencer tasks and the two sync pins.
  Assumes the bench calls run_wait one task at a time.
*/
`timescale 1ns/1ns
module stps_partner (
  input wire logic i_ref_clk,
  output logic o_vsync_a,
  output logic o_vsync_b,
  output logic [1:0] o_task_start,
  output logic [1:0] o_task_wait
);
  initial begin
    o_vsync_a = 1'h0;
    o_vsync_b = 1'h0;
    o_task_start = 2'h0;
    o_task_wait = 2'h0;
  end
  // Syncs are held six cycles so the pin synchroniser cannot miss them.
  task automatic run_wait(input logic t, input logic on_a, input logic [1:0] n);
    @(posedge i_ref_clk);
    o_task_start[t] <= 1'h1;
    @(posedge i_ref_clk);
    o_task_start[t] <= 1'h0;
    o_task_wait[t] <= 1'h1;
    repeat (n) begin
      repeat (6) @(posedge i_ref_clk);
      if (on_a) begin
        o_vsync_a <= 1'h1;
      end else begin
        o_vsync_b <= 1'h1;
      end
      repeat (6) @(posedge i_ref_clk);
      o_vsync_a <= 1'h0;
      o_vsync_b <= 1'h0;
    end
    repeat (40) @(posedge i_ref_clk);
    o_task_wait[t] <= 1'h0;
  endtask
endmodule // stps_partner

// [tb/test_stps_top.sv]
/*
  Bench for stps_top: register calls, event pulses and a time-out table.
  Assumes stps_partner plays the sequencer tasks and sync pins.
*/
`timescale 1ns/1ns
module test_stps_top;
  import stps_pkg::*;
  logic i_ref_clk = 1'h0;
  logic i_reset = 1'h1;
  logic i_wr = 1'h0;
  logic i_rd = 1'h0;
  logic i_seq_running = 1'h0;
  logic [11:0] i_addr = 12'h000;
  logic [31:0] i_wdata = 32'h0000_0000;
  logic [31:0] o_rdata;
  logic i_vsync_a, i_vsync_b, o_irq;
  logic i_bus_parity_fault = 1'h0;
  logic i_bus_abort_fault = 1'h0;
  logic i_realtime_parity_fault = 1'h0;
  logic [1:0] i_task_cmd_irq = 2'h0;
  logic [1:0] i_task_late = 2'h0;
  logic [1:0] i_task_error = 2'h0;
  logic [1:0] i_task_start, i_task_wait, o_task_timeout_flag;
  int n_fail = 0;
  int comparisons = 0;
  logic [11:0] regs [6] = '{OFF_TASK0_TIMEOUT_CONFIG, OFF_TASK1_TIMEOUT_CONFIG, OFF_PRIMARY_STATUS,
    OFF_INTERRUPT_MASK, OFF_INTERRUPT_PENDING, 12'h100};
  // Digits: expected flag, task, syncs on port A, sync count, then the configuration.
  logic [47:0] rows [9] = '{48'h0000_0000_0003, 48'h0000_4000_0000, 48'h1000_4000_0003,
    48'h0112_8200_0000, 48'h0101_8200_0000, 48'h1102_8200_0000, 48'h1112_a200_0000,
    48'h1001_c100_ffff, 48'h0003_8000_0000};
  always #50 i_ref_clk = ~i_ref_clk;
  stps_top DUT (.*);
  stps_partner u_far (.i_ref_clk(i_ref_clk), .o_vsync_a(i_vsync_a), .o_vsync_b(i_vsync_b),
    .o_task_start(i_task_start), .o_task_wait(i_task_wait));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge i_ref_clk);
    i_wr <= 1'h1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_ref_clk);
    i_wr <= 1'h0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    @(posedge i_ref_clk);
    i_rd <= 1'h1;
    i_addr <= a;
    @(posedge i_ref_clk);
    i_rd <= 1'h0;
    #1;
    chk(o_rdata, exp);
  endtask
  task automatic pulse(input logic [8:0] v);
    @(posedge i_ref_clk);
    {i_bus_parity_fault, i_bus_abort_fault, i_realtime_parity_fault, i_task_cmd_irq, i_task_late, i_task_error} <= v;
    @(posedge i_ref_clk);
    {i_bus_parity_fault, i_bus_abort_fault, i_realtime_parity_fault, i_task_cmd_irq, i_task_late, i_task_error} <= 9'h000;
  endtask
  task automatic report_and_stop;
    $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    #(100 * 6000);
    n_fail++;
    report_and_stop;
  end
  initial begin
    repeat (3) @(posedge i_ref_clk);
    i_reset <= 1'h0;
    foreach (regs[k]) rd(regs[k], 32'h0000_0000);
    wr(OFF_TASK0_TIMEOUT_CONFIG, 32'hffff_ffff);
    rd(OFF_TASK0_TIMEOUT_CONFIG, 32'hefff_ffff);
    wr(OFF_TASK1_TIMEOUT_CONFIG, 32'hffff_ffff);
    rd(OFF_TASK1_TIMEOUT_CONFIG, 32'hefff_ffff);
    wr(12'h100, 32'hffff_ffff);
    rd(12'h100, 32'h0000_0000);
    wr(OFF_INTERRUPT_MASK, 32'hffff_ffff);
    rd(OFF_INTERRUPT_MASK, 32'hffe0_0000);
    pulse(9'h1ff);
    rd(OFF_PRIMARY_STATUS, 32'hff80_0000);
    rd(OFF_INTERRUPT_PENDING, 32'hff80_0000);
    chk(32'(o_irq), 32'h0000_0001);
    wr(OFF_INTERRUPT_PENDING, 32'hffff_ffff);
    rd(OFF_PRIMARY_STATUS, 32'h2780_0000);
    chk(32'(o_irq), 32'h0000_0000);
    @(posedge i_ref_clk);
    i_seq_running <= 1'h1;
    u_far.run_wait(1'h0, 1'h0, 2'h0);
    u_far.run_wait(1'h1, 1'h0, 2'h0);
    rd(OFF_PRIMARY_STATUS, 32'h0000_0000);
    wr(OFF_INTERRUPT_MASK, 32'h0000_0000);
    pulse(9'h080);
    rd(OFF_INTERRUPT_PENDING, 32'h0000_0000);
    wr(OFF_INTERRUPT_MASK, 32'h8000_0000);
    wr(OFF_PRIMARY_STATUS, 32'h7fff_ffff);
    rd(OFF_INTERRUPT_PENDING, 32'h0000_0000);
    wr(OFF_PRIMARY_STATUS, 32'h8000_0000);
    rd(OFF_PRIMARY_STATUS, 32'h4000_0000);
    rd(OFF_INTERRUPT_PENDING, 32'h8000_0000);
    chk(32'(o_irq), 32'h0000_0001);
    wr(OFF_INTERRUPT_PENDING, 32'hffff_ffff);
    wr(OFF_INTERRUPT_MASK, 32'hffe0_0000);
    foreach (rows[k]) begin
      wr(rows[k][40] ? OFF_TASK1_TIMEOUT_CONFIG : OFF_TASK0_TIMEOUT_CONFIG, rows[k][31:0]);
      u_far.run_wait(rows[k][40], rows[k][36], rows[k][33:32]);
      @(posedge i_ref_clk);
      #1;
      chk(32'(o_task_timeout_flag[rows[k][40]]), 32'(rows[k][44]));
    end
    rd(OFF_PRIMARY_STATUS, 32'h0040_0000);
    rd(OFF_INTERRUPT_PENDING, 32'h0060_0000);
    report_and_stop;
  end
endmodule // test_stps_top
